/* File: dv/dbcc_pin_model.sv */
/*
  Pin partner: event sources on capture pins, loads on compare pins.
  Assumes the bench sets the source levels; enables are active low.
*/
`timescale 1ns/100ps
module dbcc_pin_model (
  input wire logic [31:0] lvl_i, // source level per pin
  input wire logic [31:0] drv_i, // level driven by the unit
  input wire logic [31:0] oe_n_i, // low while the unit drives
  output logic [31:0] pin_o // resolved pin level
);
  // one pin per channel, the unit wins while it drives
  assign pin_o = (drv_i & ~oe_n_i) | (lvl_i & oe_n_i);
endmodule // dbcc_pin_model

/* File: dv/dbcc_top_sva.sv */
/*
  Checker of the capture/compare unit: channel 0, the reload of timer 0 and the step of timer 2.
  Assumes a bind onto dbcc_top and configuration held steady around events.
*/
`timescale 1ns/100ps
`include "dbcc_params.svh"
module dbcc_chk (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire dbcc_pkg::dbcc_tmr_cfg_s [`DBCC_TMR_NUM-1:0] tmr_cfg_i, // timers
  input wire dbcc_pkg::dbcc_ch_cfg_s [`DBCC_CH_NUM-1:0] ch_cfg_i, // channels
  input wire logic [`DBCC_CH_NUM-1:0] cc_pin_i, // pin levels
  input wire logic [`DBCC_CH_NUM-1:0] cc_pin_o, // pin drive
  input wire logic [`DBCC_CH_NUM-1:0] cc_pin_oe_n_o, // low while driving
  input wire logic [`DBCC_CH_NUM-1:0] cc_irq_o, // requests
  input wire logic [`DBCC_CH_NUM-1:0][`DBCC_TMR_W-1:0] cc_val_o, // registers
  input wire logic [`DBCC_TMR_NUM-1:0][`DBCC_TMR_W-1:0] tmr_val_o // timers
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // timer of channel 0; a step is seen as a change of its count
  dbcc_pkg::dbcc_mode_e md;
  dbcc_pkg::dbcc_edge_e eg;
  logic [15:0] tv;
  logic [15:0] tv_q;
  logic st;
  logic mt;
  assign md = ch_cfg_i[0].mode;
  assign eg = ch_cfg_i[0].edge_sel;
  assign tv = tmr_val_o[{1'b0, ch_cfg_i[0].tsel}];
  assign st = tv != tv_q;
  assign mt = st && tv == cc_val_o[0];
  always_ff @(posedge ref_clk_i) begin
    tv_q <= tv;
  end
  ////////////////////////////////////////////////////////////////////////////
  // capture latches timer
  property p_cap_val;
    md == dbcc_pkg::CC_CAPTURE && eg != dbcc_pkg::EDGE_FALL &&
      $rose(cc_pin_i[0]) |=> cc_val_o[0] == $past(tv);
  endproperty
  a_cap_val: assert property (p_cap_val)
    else $error("capture value wrong");
  property p_cap_irq;
    md == dbcc_pkg::CC_CAPTURE && ((eg == dbcc_pkg::EDGE_RISE &&
      $rose(cc_pin_i[0])) || (eg == dbcc_pkg::EDGE_BOTH &&
      $changed(cc_pin_i[0]))) |=> cc_irq_o[0];
  endproperty
  a_cap_irq: assert property (p_cap_irq)
    else $error("capture request missing");
  property p_cap_skip;
    md == dbcc_pkg::CC_CAPTURE && eg == dbcc_pkg::EDGE_RISE &&
      $fell(cc_pin_i[0]) |=> !cc_irq_o[0];
  endproperty
  a_cap_skip: assert property (p_cap_skip)
    else $error("request on unselected edge");
  property p_cmp_irq;
    md == dbcc_pkg::CC_CMP0 && mt |=> cc_irq_o[0];
  endproperty
  a_cmp_irq: assert property (p_cmp_irq)
    else $error("compare request missing");
  property p_cmp0_pin;
    md == dbcc_pkg::CC_CMP0 |=> cc_pin_oe_n_o[0];
  endproperty
  a_cmp0_pin: assert property (p_cmp0_pin)
    else $error("mode zero drives pin");
  property p_cmp1_tog;
    md == dbcc_pkg::CC_CMP1 && mt |=> cc_pin_o[0] != $past(cc_pin_o[0]);
  endproperty
  a_cmp1_tog: assert property (p_cmp1_tog)
    else $error("pin did not toggle");
  property p_cmp3_ovf;
    md == dbcc_pkg::CC_CMP3 && st && tv_q == 16'hFFFF && !mt |=> !cc_pin_o[0];
  endproperty
  a_cmp3_ovf: assert property (p_cmp3_ovf)
    else $error("pin not cleared on overflow");
  property p_reload;
    $changed(tmr_val_o[0]) && $past(tmr_val_o[0]) == 16'hFFFF |->
      tmr_val_o[0] == $past(tmr_cfg_i[0].reload);
  endproperty
  a_reload: assert property (p_reload)
    else $error("timer reload wrong");
  property p_count;
    $changed(tmr_val_o[2]) && $past(tmr_val_o[2]) != 16'hFFFF |->
      tmr_val_o[2] == $past(tmr_val_o[2]) + 16'h0001;
  endproperty
  a_count: assert property (p_count)
    else $error("timer step not one");
endmodule // dbcc_chk

/* File: dv/dbcc_top_test.sv */
/*
  Bench of dbcc_top: reset, capture edges, compare modes, timer reload.
  Assumes the checker and pin model are compiled before it.
*/
`timescale 1ns/100ps
module dbcc_top_test;
  logic ref_clk_i = 0, rst_i = 1, aux = 0, hit, p0 = 0;
  dbcc_pkg::dbcc_tmr_cfg_s [3:0] tcfg;
  dbcc_pkg::dbcc_ch_cfg_s [31:0] ccfg;
  dbcc_pkg::dbcc_wr_s wr;
  logic [1:0] ext;
  logic [31:0] lvl, pin_i, pin_o, oe_n, irq;
  logic [31:0][15:0] ccv;
  logic [3:0][15:0] tv;
  logic [15:0] exp_v, t;
  int miscompares = 0, tests_run = 0, cyc = 0, n_irq, n_tog, c;
  dbcc_top i_dut (.ref_clk_i, .rst_i, .tmr_cfg_i(tcfg), .ch_cfg_i(ccfg),
    .wr_i(wr), .aux_ovf_i(aux), .ext_count_i(ext), .cc_pin_i(pin_i),
    .cc_pin_o(pin_o), .cc_pin_oe_n_o(oe_n), .cc_irq_o(irq), .cc_val_o(ccv),
    .tmr_val_o(tv));
  dbcc_pin_model i_pins (.lvl_i(lvl), .drv_i(pin_o), .oe_n_i(oe_n),
    .pin_o(pin_i));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // cycle ceiling, about one timer wrap plus margin
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      results();
    end
    n_irq += irq[0];
    if (pin_o[0] !== p0) n_tog++;
    p0 = pin_o[0];
    #1 ext <= 2'($urandom);
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write strobe starts after an edge so no same-step double assignment
  task automatic wr_cc(int i, logic [15:0] d);
    tick();
    wr = '{1'b1, 5'(i), d};
    tick();
    wr.en = 0;
  endtask
  task automatic step();
    tick();
    aux = 1;
    tick();
    aux = 0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h46f9d93b));
    {lvl, ext, wr, ccfg} = '0;
    tcfg[0] = '{1'b1, dbcc_pkg::SRC_AUX, 3'h0, 16'hFFF0};
    tcfg[1] = '{1'b1, dbcc_pkg::SRC_PRESCALE, 3'($urandom_range(2)), 16'h0};
    tcfg[2] = '{1'b1, dbcc_pkg::SRC_EXT, 3'h0, 16'($urandom_range(65534))};
    tcfg[3] = '{1'b1, dbcc_pkg::SRC_PRESCALE, 3'h0, 16'h0};
    tick(5);
    chk("oe_n reset", 16'hFFFF, oe_n[31:16]);
    chk("timer reset", 16'h0, tv[2]);
    rst_i = 0;
    // prescaled timer 3 steps once every eight clocks
    t = tv[3];
    while (tv[3] === t) tick();
    t = tv[3];
    tick(7);
    chk("prescale hold", t, tv[3]);
    tick();
    chk("prescale step", t + 16'h0001, tv[3]);
    // captures on random channels, every edge kind twice; first on ch 0
    for (int e = 0; e < 6; e++) begin
      c = e == 0 ? 0 : $urandom_range(31);
      ccfg[c] = '{dbcc_pkg::CC_CAPTURE, 1'($urandom),
        dbcc_pkg::dbcc_edge_e'(e % 3)};
      exp_v = 16'($urandom);
      wr_cc(c, exp_v);
      for (int d = 1; d >= 0; d--) begin
        tick();
        lvl[c] = d[0];
        t = tv[{c[4], ccfg[c].tsel}];
        tick();
        hit = e % 3 == 2 || e % 3 == 1 - d;
        if (hit) exp_v = t;
        chk("capture value", exp_v, ccv[c]);
        chk("capture irq", 16'(hit), 16'(irq[c]));
      end
      ccfg[c].mode = dbcc_pkg::CC_OFF;
    end
    // run timer 0 up to its reload value, then 16-step periods
    aux = 1;
    while (tv[0] !== 16'hFFF0) tick();
    aux = 0;
    wr_cc(8, 16'hFFF8);
    // compare modes: matches at FFF4, rewrite to FFFC, partner FFF8
    for (int k = 2; k < 7; k++) begin
      ccfg[0] = '{dbcc_pkg::dbcc_mode_e'(k), 1'b0, dbcc_pkg::EDGE_RISE};
      ccfg[8].mode = k == 6 ? dbcc_pkg::CC_CMP0 : dbcc_pkg::CC_OFF;
      wr_cc(0, 16'hFFF4);
      n_irq = 0;
      n_tog = 0;
      for (int i = 1; i <= 32; i++) begin
        step();
        if (i == 6) wr_cc(0, 16'hFFFC);
        if (k == 5 && (i == 20 || i == 30))
          chk("mode three pin", 16'(i == 30), 16'(pin_o[0]));
      end
      tick(3);
      chk("irq count", 16'(k == 4 || k == 5 ? 2 : 3), 16'(n_irq));
      if (k != 5)
        chk("toggles", 16'(k == 3 ? 3 : k == 6 ? 5 : 0), 16'(n_tog));
      chk("pin idle", 16'(k == 2 || k == 4), 16'(oe_n[0]));
    end
    results();
  end
endmodule // dbcc_top_test
bind dbcc_top dbcc_chk i_chk (.ref_clk_i, .rst_i, .tmr_cfg_i, .ch_cfg_i,
  .cc_pin_i, .cc_pin_o, .cc_pin_oe_n_o, .cc_irq_o, .cc_val_o, .tmr_val_o);

/* File: pkg/dbcc_params.svh */
/*
  Constants of the dual bank capture/compare unit: sizes, timing counts
  and reset values. Assumes it is included by the package, both rtl files and the checker.
*/
// What this block does
// - thirty-two channels, sixteen clock phase unit resolution
// - four reloadable 16-bit timers, two per bank
// - timer count clock prescaled or auxiliary overflow
// - first timer of each bank counts external events
// - sixteen channels per bank, timer and function selectable
// - each channel owns one pin, input or output
// - capture copies allocated timer on pin event
// - capture event raises that channel's interrupt
// - capture edge rising, falling or both
// - compare channels matched continuously against allocated timer
// - mode zero interrupts only, many per period
// - mode one toggles pin on every match
// - mode two interrupts at most once per period
// - mode three sets pin on match, clears on overflow
// - double mode: two registers toggle one pin
`ifndef DBCC_PARAMS_SVH
`define DBCC_PARAMS_SVH

`define DBCC_TMR_W 16
`define DBCC_BANKS 2
`define DBCC_CH_PER_BANK 16
`define DBCC_CH_NUM 32
`define DBCC_TMR_NUM 4
`define DBCC_HALF_BANK 8
// finest time step in clock phase units, two units per system clock
`define DBCC_RES_TCL 16
`define DBCC_TCL_PER_CLK 2
`define DBCC_BASE_DIV (`DBCC_RES_TCL / `DBCC_TCL_PER_CLK)
`define DBCC_PRE_W 10
`define DBCC_PRESEL_W 3
`define DBCC_TMR_MAX 16'hFFFF
`define DBCC_TMR_RST 16'h0000
`define DBCC_CC_RST 16'h0000

`endif

/* File: pkg/dbcc_pkg.sv */
/*
  Types of the dual bank capture/compare unit. Assumes the constants
  header sits beside it on the include path.
*/
`include "dbcc_params.svh"

package dbcc_pkg;

  typedef enum logic [2:0] {
    CC_OFF, CC_CAPTURE, CC_CMP0, CC_CMP1, CC_CMP2, CC_CMP3, CC_DOUBLE
  } dbcc_mode_e;

  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} dbcc_edge_e;

  typedef enum logic [1:0] {SRC_PRESCALE, SRC_AUX, SRC_EXT} dbcc_src_e;

  // per channel configuration
  typedef struct packed {
    dbcc_mode_e mode;
    logic tsel;
    dbcc_edge_e edge_sel;
  } dbcc_ch_cfg_s;

  // per timer configuration
  typedef struct packed {
    logic run;
    dbcc_src_e src;
    logic [`DBCC_PRESEL_W-1:0] presel;
    logic [`DBCC_TMR_W-1:0] reload;
  } dbcc_tmr_cfg_s;

  // software write into one channel register
  typedef struct packed {
    logic en;
    logic [4:0] idx;
    logic [`DBCC_TMR_W-1:0] data;
  } dbcc_wr_s;

  typedef struct packed {
    logic [`DBCC_PRE_W-1:0] pre;
    logic [`DBCC_TMR_W-1:0] val;
    logic ext_prev;
    logic step;
    logic ovf;
  } dbcc_tmr_state_s;

  typedef struct packed {
    logic [`DBCC_CH_NUM-1:0][`DBCC_TMR_W-1:0] cc;
    logic [`DBCC_CH_NUM-1:0] pin;
    logic [`DBCC_CH_NUM-1:0] oe_n;
    logic [`DBCC_CH_NUM-1:0] pin_prev;
    logic [`DBCC_CH_NUM-1:0] armed;
    logic [`DBCC_CH_NUM-1:0] irq;
  } dbcc_state_s;

endpackage

/* File: rtl/dbcc_timer.sv */
/*
  One reloadable time-base timer with its count clock selection.
  Assumes inputs synchronous to ref_clk_i and a one-cycle aux pulse.
*/
`timescale 1ns/100ps
`include "dbcc_params.svh"

module dbcc_timer #(
  parameter bit HAS_EXT = 1'b1
) (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire dbcc_pkg::dbcc_tmr_cfg_s cfg_i, // run, source, reload
  input wire logic aux_ovf_i, // auxiliary timer over/underflow pulse
  input wire logic ext_i, // external count input level
  output logic [`DBCC_TMR_W-1:0] val_o, // timer count
  output logic step_o, // count advanced last edge
  output logic ovf_o // timer overflowed last edge
);

  dbcc_pkg::dbcc_tmr_state_s st;
  dbcc_pkg::dbcc_tmr_state_s next_st;
  logic ext_rise;
  logic tick;

  // last prescaler count before a step: base divider times two to sel, less one
  function automatic logic [`DBCC_PRE_W-1:0] pre_limit(
    input logic [`DBCC_PRESEL_W-1:0] sel);
    logic [`DBCC_PRE_W:0] span;
    span = (`DBCC_PRE_W+1)'(`DBCC_BASE_DIV) << sel;
    return `DBCC_PRE_W'(span - 1'b1);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // count clock selection and counting
  always_comb begin
    next_st = st;
    next_st.step = 1'b0;
    next_st.ovf = 1'b0;
    next_st.ext_prev = ext_i;
    ext_rise = HAS_EXT && ext_i && !st.ext_prev;
    tick = 1'b0;
    case (cfg_i.src)
      dbcc_pkg::SRC_PRESCALE: begin
        if (st.pre >= pre_limit(cfg_i.presel)) begin
          next_st.pre = '0;
          tick = cfg_i.run;
        end else begin
          next_st.pre = st.pre + 1'b1;
        end
      end
      dbcc_pkg::SRC_AUX: tick = cfg_i.run && aux_ovf_i;
      dbcc_pkg::SRC_EXT: tick = cfg_i.run && ext_rise;
      default: tick = 1'b0;
    endcase
    if (tick) begin
      next_st.step = 1'b1;
      if (st.val == `DBCC_TMR_MAX) begin
        next_st.val = cfg_i.reload;
        next_st.ovf = 1'b1;
      end else begin
        next_st.val = st.val + 1'b1;
      end
    end
  end

  // the prescaler stays live while stopped, so a restart is in phase
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '{pre: '0, val: `DBCC_TMR_RST, ext_prev: 1'b0,
              step: 1'b0, ovf: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign val_o = st.val;
  assign step_o = st.step;
  assign ovf_o = st.ovf;

endmodule // dbcc_timer

/* File: rtl/dbcc_top.sv */
/*
  Dual bank capture/compare unit: four time-base timers and thirty-two
  channel registers, each with its own pin. Assumes all inputs are
  synchronous to ref_clk_i and that configuration is given as ports.
*/
`timescale 1ns/100ps
`include "dbcc_params.svh"

module dbcc_top (
  input wire logic ref_clk_i, // system clock, 25 MHz
  input wire logic rst_i, // synchronous reset, high
  input wire dbcc_pkg::dbcc_tmr_cfg_s [`DBCC_TMR_NUM-1:0] tmr_cfg_i, // timers
  input wire dbcc_pkg::dbcc_ch_cfg_s [`DBCC_CH_NUM-1:0] ch_cfg_i, // channels
  input wire dbcc_pkg::dbcc_wr_s wr_i, // channel register write
  input wire logic aux_ovf_i, // auxiliary general timer overflow pulse
  input wire logic [`DBCC_BANKS-1:0] ext_count_i, // bank first timer input
  input wire logic [`DBCC_CH_NUM-1:0] cc_pin_i, // channel pin levels
  output logic [`DBCC_CH_NUM-1:0] cc_pin_o, // channel pin drive level
  output logic [`DBCC_CH_NUM-1:0] cc_pin_oe_n_o, // low while driving
  output logic [`DBCC_CH_NUM-1:0] cc_irq_o, // channel request pulses
  output logic [`DBCC_CH_NUM-1:0][`DBCC_TMR_W-1:0] cc_val_o, // registers
  output logic [`DBCC_TMR_NUM-1:0][`DBCC_TMR_W-1:0] tmr_val_o // timers
);

  dbcc_pkg::dbcc_state_s st;
  dbcc_pkg::dbcc_state_s next_st;
  logic [`DBCC_TMR_NUM-1:0] tmr_step;
  logic [`DBCC_TMR_NUM-1:0] tmr_ovf;

  // timer index serving a channel: bank pair plus its own select bit
  function automatic logic [1:0] tmr_of(input int unsigned ch,
                                        input logic tsel);
    logic [1:0] bank;
    bank = 2'(ch / `DBCC_CH_PER_BANK);
    return {bank[0], tsel};
  endfunction

  // a compare hit: the timer just stepped onto the register value
  function automatic logic hit(input logic stepped,
                               input logic [`DBCC_TMR_W-1:0] tv,
                               input logic [`DBCC_TMR_W-1:0] cv);
    return stepped && (tv == cv);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // time bases
  // two timers per bank
  for (genvar t = 0; t < `DBCC_TMR_NUM; t++) begin : g_tmr
    // only the first timer of a bank sees the external input
    dbcc_timer #(
      .HAS_EXT(t % 2 == 0)
    ) u_tmr (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .cfg_i(tmr_cfg_i[t]),
      .aux_ovf_i(aux_ovf_i),
      .ext_i(ext_count_i[t / 2]),
      .val_o(tmr_val_o[t]),
      .step_o(tmr_step[t]),
      .ovf_o(tmr_ovf[t])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // channel behaviour
  // all thirty-two channels in one loop
  always_comb begin
    logic [1:0] ti;
    logic [`DBCC_TMR_W-1:0] tv;
    logic stp;
    logic ov;
    logic rise;
    logic fall;
    logic ev;
    logic arm;
    logic m;
    dbcc_pkg::dbcc_ch_cfg_s cfg;
    ti = '0;
    tv = '0;
    stp = 1'b0;
    ov = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    ev = 1'b0;
    arm = 1'b0;
    m = 1'b0;
    cfg = '0;
    next_st = st;
    next_st.irq = '0;
    next_st.pin_prev = cc_pin_i;
    for (int unsigned c = 0; c < `DBCC_CH_NUM; c++) begin
      cfg = ch_cfg_i[c];
      ti = tmr_of(c, cfg.tsel);
      tv = tmr_val_o[ti];
      stp = tmr_step[ti];
      ov = tmr_ovf[ti];
      // an overflow re-arms the once-per-period modes
      arm = st.armed[c] | ov;
      m = hit(stp, tv, st.cc[c]);
      // software write; a capture in the same cycle wins below
      if (wr_i.en && (wr_i.idx == 5'(c))) begin
        next_st.cc[c] = wr_i.data;
      end
      next_st.oe_n[c] = 1'b1;
      case (cfg.mode)
        dbcc_pkg::CC_CAPTURE: begin
          rise = cc_pin_i[c] && !st.pin_prev[c];
          fall = !cc_pin_i[c] && st.pin_prev[c];
          case (cfg.edge_sel)
            dbcc_pkg::EDGE_RISE: ev = rise;
            dbcc_pkg::EDGE_FALL: ev = fall;
            dbcc_pkg::EDGE_BOTH: ev = rise | fall;
            default: ev = 1'b0;
          endcase
          if (ev) begin
            next_st.cc[c] = tv;
            next_st.irq[c] = 1'b1;
          end
        end
        dbcc_pkg::CC_CMP0: begin
          next_st.irq[c] = m;
        end
        dbcc_pkg::CC_CMP1: begin
          next_st.oe_n[c] = 1'b0;
          next_st.irq[c] = m;
          if (m) begin
            next_st.pin[c] = !st.pin[c];
          end
        end
        dbcc_pkg::CC_CMP2: begin
          next_st.armed[c] = arm;
          if (m && arm) begin
            next_st.irq[c] = 1'b1;
            next_st.armed[c] = 1'b0;
          end
        end
        // set on match, clear on overflow
        dbcc_pkg::CC_CMP3: begin
          next_st.oe_n[c] = 1'b0;
          next_st.armed[c] = arm;
          if (ov) begin
            next_st.pin[c] = 1'b0;
          end
          if (m && arm) begin
            next_st.pin[c] = 1'b1;
            next_st.irq[c] = 1'b1;
            next_st.armed[c] = 1'b0;
          end
        end
        // lower channel and its upper partner share the pin
        dbcc_pkg::CC_DOUBLE: begin
          next_st.oe_n[c] = 1'b0;
          next_st.irq[c] = m;
          if ((c % `DBCC_CH_PER_BANK) < `DBCC_HALF_BANK) begin
            m = m | hit(stp, tv, st.cc[c + `DBCC_HALF_BANK]);
          end
          if (m) begin
            next_st.pin[c] = !st.pin[c];
          end
        end
        default: begin
          next_st.armed[c] = 1'b1;
        end
      endcase
    end
  end

  // pins stay undriven and low after reset; limited modes start armed
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '{cc: {`DBCC_CH_NUM{`DBCC_CC_RST}}, pin: '0, oe_n: '1,
              pin_prev: '0, armed: '1, irq: '0};
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign cc_pin_o = st.pin;
  assign cc_pin_oe_n_o = st.oe_n;
  assign cc_irq_o = st.irq;
  assign cc_val_o = st.cc;

endmodule // dbcc_top
